// [hw/dsps_regs.vh]
// Register offsets, field positions, reset values and phase counts of the sequencer
`ifndef DSPS_REGS_VH
`define DSPS_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define DSPS_CTRL_OFS      4'h0
`define DSPS_STAT_OFS      4'h4
`define DSPS_RESULT_OFS    4'h8
`define DSPS_PCNT_OFS      4'hC

// ****************************************
// Control fields
// ****************************************
`define DSPS_CTRL_RUN_BIT  0
`define DSPS_CTRL_GO_BIT   1
`define DSPS_CTRL_RST      2'h0

// ****************************************
// Status fields
// ****************************************
`define DSPS_STAT_PH_LSB   0
`define DSPS_STAT_BUSY_BIT 4
`define DSPS_STAT_POL_BIT  5
`define DSPS_STAT_LOW_BIT  6
`define DSPS_STAT_HIGH_BIT 7
`define DSPS_STAT_OR_BIT   8
`define DSPS_STAT_REQ_BIT  9

// ****************************************
// Phase and frame lengths and result range limits in clock cycles
// ****************************************
`define DSPS_NULL_CYC      16'h2648
`define DSPS_NULL_OR_CYC   16'h0ED8
`define DSPS_INT_CYC       16'h2710
`define DSPS_DEINT_CYC     16'h4E21
`define DSPS_CLR_CYC       16'h00C8
`define DSPS_CLR_OR_CYC    16'h1838
`define DSPS_FRAME_CYC     16'h9C42
`define DSPS_LOW_LIMIT     16'h0708
`define DSPS_HIGH_LIMIT    16'h4E1F

`endif

// [hw/dsps_sequencer.v]
// Dual-slope converter phase sequencer with a classic Wishbone register slave
`default_nettype none
`include "dsps_regs.vh"

// Summary of operation
// RQ1 - Four phases in fixed order from counters
// RQ2 - Null: inputs to common, loop, ref charging
// RQ3 - Null lasts at least 9800 cycles
// RQ4 - After overrange null shortens to 3800
// RQ5 - Integration exactly 10000 cycles on input pins
// RQ6 - Capture comparator polarity ending integration
// RQ7 - Captured polarity selects reference capacitor terminal
// RQ8 - Return ends at 20001 or crossing
// RQ9 - Sample comparator each clock, end on change
// RQ10 - Return count captured as result
// RQ11 - Clear: common input, buffer from comparator; sw_in_common_o is driven in null only, clear drives sw_clear_loop_o
// RQ12 - Clear lasts 100 to 200 counts normally
// RQ13 - No crossing: out of range, clear 6200
// RQ14 - Request high: back to back 40002-cycle measurements
// RQ15 - Request low: finish, hold null, keep result
// RQ16 - Request rise starts conversion within 10001 cycles
// RQ17 - Request pulses during return are ignored
// RQ18 - Short request pulse in null starts conversion
// RQ19 - Busy rises at integration, falls after crossing
// RQ20 - Result latched cycle after busy falls
// RQ21 - Busy lasts 10000 plus return plus one
// RQ22 - Receiver subtracts 10001 from gated count
// RQ23 - Drive range flags, busy, latch pulse
// RQ24 - Low flag at 1800 or less, high above 19999
// RQ25 - Low clears at integration, high at return
// RQ26 - Polarity output updated at return start
// RQ27 - Null fills out the fixed measurement length
// RQ28 - Comparator and request inputs are synchronised
// RQ29 - Reset: null phase, results and flags cleared
module dsps_sequencer #(
    parameter [15:0] NULL_CYC    = `DSPS_NULL_CYC,
    parameter [15:0] NULL_OR_CYC = `DSPS_NULL_OR_CYC,
    parameter [15:0] INT_CYC     = `DSPS_INT_CYC,
    parameter [15:0] DEINT_CYC   = `DSPS_DEINT_CYC,
    parameter [15:0] CLR_CYC     = `DSPS_CLR_CYC,
    parameter [15:0] CLR_OR_CYC  = `DSPS_CLR_OR_CYC,
    parameter [15:0] FRAME_CYC   = `DSPS_FRAME_CYC
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        comp_i,
    input  wire        run_req_i,
    output reg         sw_in_common_o,
    output reg         sw_null_loop_o,
    output reg         sw_ref_charge_o,
    output reg         sw_in_pins_o,
    output reg         sw_ref_buf_o,
    output reg         ref_pol_sel_o,
    output reg         sw_clear_loop_o,
    output reg         busy_o,
    output reg         result_low_flag_o,
    output reg         result_high_flag_o,
    output reg         polarity_o,
    output reg         latch_strobe_o,
    output reg  [15:0] result_o
);

    // ****************************************
    // Phase encoding
    // ****************************************
    localparam [3:0] ST_NULL  = 4'h1;
    localparam [3:0] ST_INT   = 4'h2;
    localparam [3:0] ST_DEINT = 4'h4;
    localparam [3:0] ST_CLR   = 4'h8;
    localparam [15:0] LOW_LIMIT  = `DSPS_LOW_LIMIT;
    localparam [15:0] HIGH_LIMIT = `DSPS_HIGH_LIMIT;
    localparam [16:0] RET_MAX    = {1'b0, INT_CYC} + {1'b0, DEINT_CYC};

    // ****************************************
    // State
    // ****************************************
    reg [3:0]  state_reg;
    reg [3:0]  state_next;
    reg [15:0] cnt_reg;
    reg [15:0] cnt_next;
    reg [15:0] frame_reg;
    reg        pol_reg;
    reg        or_last_reg;
    reg        start_seen_reg;
    reg        ld_pend_reg;
    reg [15:0] cap_reg;
    reg        comp_m_reg;
    reg        comp_s_reg;
    reg        req_m_reg;
    reg        req_s_reg;
    reg [1:0]  ctrl_reg;
    reg        sw_go_reg;

    wire        bus_req;
    wire        bus_wr;
    wire        ctrl_hit;
    wire        ctrl_wr;
    wire        run_lvl;
    wire [15:0] null_min;
    wire [15:0] clr_len;
    wire        null_done;
    wire        frame_end;
    wire        go;
    wire        crossing;
    wire        deint_end;
    wire        null_go;
    wire        int_exit;
    wire        deint_exit;
    wire        req_window;
    wire        cap_low;
    wire        cap_high;
    wire [31:0] status_word;

    // ****************************************
    // Derived conditions
    // ****************************************
    assign bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr     = bus_req & wb_we_i & wb_sel_i[0];
    assign ctrl_hit   = (wb_adr_i == `DSPS_CTRL_OFS);
    // GO and RUN live in byte lane 0, so other lanes leave them alone
    assign ctrl_wr    = bus_wr & ctrl_hit;
    assign run_lvl    = req_s_reg | ctrl_reg[`DSPS_CTRL_RUN_BIT];
    assign null_min   = or_last_reg ? NULL_OR_CYC : NULL_CYC;
    assign clr_len    = or_last_reg ? CLR_OR_CYC : CLR_CYC;
    assign null_done  = (cnt_reg >= null_min - 16'h0001);   // see RQ3, RQ4
    assign frame_end  = (frame_reg >= FRAME_CYC - 16'h0001);
    assign go         = null_done & frame_end & (run_lvl | start_seen_reg); // see RQ16
    // Judged against the captured sign, so either slope direction ends the return
    assign crossing   = (comp_s_reg != pol_reg);
    assign deint_end  = (cnt_reg == DEINT_CYC - 16'h0001);
    assign null_go    = (state_reg == ST_NULL) & go;
    assign int_exit   = (state_reg == ST_INT) & (state_next == ST_DEINT);
    assign deint_exit = (state_reg == ST_DEINT) & (state_next == ST_CLR);
    // Requests only count once the longest return would be over
    assign req_window = ((state_reg == ST_NULL) | (state_reg == ST_CLR)) &
                        ({1'b0, frame_reg} >= RET_MAX);
    assign cap_low    = (cap_reg <= LOW_LIMIT);
    assign cap_high   = (cap_reg > HIGH_LIMIT);

    // ****************************************
    // Next-phase decision
    // ****************************************
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 16'h0001;
        case (state_reg)
            ST_NULL: begin
                if (go) begin
                    state_next = ST_INT;      // see RQ1, RQ14
                    cnt_next   = 16'h0000;
                // Held requests wait here with the counter parked
                end else if (null_done) begin
                    cnt_next = cnt_reg;       // see RQ15
                end
            end
            ST_INT: begin
                if (cnt_reg == INT_CYC - 16'h0001) begin
                    state_next = ST_DEINT;    // see RQ5
                    cnt_next   = 16'h0000;
                end
            end
            ST_DEINT: begin
                if (crossing || deint_end) begin
                    state_next = ST_CLR;      // see RQ8, RQ9
                    cnt_next   = 16'h0000;
                end
            end
            ST_CLR: begin
                if (cnt_reg == clr_len - 16'h0001) begin
                    state_next = ST_NULL;     // see RQ12, RQ13, RQ27
                    cnt_next   = 16'h0000;
                end
            end
            default: begin
                state_next = ST_NULL;
                cnt_next   = 16'h0000;
            end
        endcase
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            comp_m_reg <= 1'b0;
            comp_s_reg <= 1'b0;
            req_m_reg  <= 1'b0;
            req_s_reg  <= 1'b0;
        end else if (ce_i) begin
            comp_m_reg <= comp_i;             // see RQ28
            comp_s_reg <= comp_m_reg;
            req_m_reg  <= run_req_i;
            req_s_reg  <= req_m_reg;
        end
    end

    // ****************************************
    // Sequencer core
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg      <= ST_NULL;        // see RQ29
            cnt_reg        <= 16'h0000;
            frame_reg      <= FRAME_CYC - 16'h0001;
            pol_reg        <= 1'b0;
            or_last_reg    <= 1'b0;
            start_seen_reg <= 1'b0;
            ld_pend_reg    <= 1'b0;
            cap_reg        <= 16'h0000;
            busy_o         <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            // Total length counted from integration start keeps 40002 per frame
            if (state_next == ST_INT && state_reg == ST_NULL) begin
                frame_reg <= 16'h0000;        // see RQ27
            end else if (!frame_end) begin
                frame_reg <= frame_reg + 16'h0001;
            end
            // Pulses before the longest return would end are dropped
            if (null_go) begin
                start_seen_reg <= 1'b0;
            end else if (req_window && (req_s_reg || sw_go_reg)) begin
                start_seen_reg <= 1'b1;       // see RQ17, RQ18
            end
            // Result and flags load one cycle after busy falls
            ld_pend_reg <= 1'b0;
            case (state_reg)
                ST_NULL: begin
                    if (go) begin
                        busy_o <= 1'b1;       // see RQ19
                    end
                end
                ST_INT: begin
                    if (state_next == ST_DEINT) begin
                        pol_reg <= comp_s_reg; // see RQ6
                    end
                end
                ST_DEINT: begin
                    if (state_next == ST_CLR) begin
                        busy_o      <= 1'b0;  // see RQ19, RQ21
                        cap_reg     <= cnt_reg; // see RQ10
                        ld_pend_reg <= 1'b1;
                        // Overrange shortens the next null; frame length stays fixed
                        or_last_reg <= ~crossing; // see RQ4, RQ13
                    end
                end
                default: begin
                    busy_o <= busy_o;
                end
            endcase
        end
    end

    // ****************************************
    // Result latches and status flags
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            result_o           <= 16'h0000;
            result_low_flag_o  <= 1'b0;
            result_high_flag_o <= 1'b0;
            polarity_o         <= 1'b0;
            latch_strobe_o     <= 1'b0;
        end else if (ce_i) begin
            latch_strobe_o <= ld_pend_reg;    // see RQ23
            if (ld_pend_reg) begin
                result_o <= cap_reg;          // see RQ20
            end
            if (null_go) begin
                result_low_flag_o <= 1'b0;    // see RQ25
            end else if (ld_pend_reg && cap_low) begin
                result_low_flag_o <= 1'b1;    // see RQ24
            end
            if (int_exit) begin
                result_high_flag_o <= 1'b0;   // see RQ25
                polarity_o         <= comp_s_reg; // see RQ26
            end else if (ld_pend_reg && cap_high) begin
                result_high_flag_o <= 1'b1;   // see RQ24
            end
        end
    end

    // ****************************************
    // Analog switch drive
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            sw_in_common_o  <= 1'b1;
            sw_null_loop_o  <= 1'b1;
            sw_ref_charge_o <= 1'b1;
            sw_in_pins_o    <= 1'b0;
            sw_ref_buf_o    <= 1'b0;
            ref_pol_sel_o   <= 1'b0;
            sw_clear_loop_o <= 1'b0;
        end else if (ce_i) begin
            // Switches follow the next phase so they move with the phase edge
            sw_in_common_o  <= (state_next == ST_NULL);  // see RQ2
            sw_null_loop_o  <= (state_next == ST_NULL);  // see RQ2
            sw_ref_charge_o <= (state_next == ST_NULL);  // see RQ2
            sw_in_pins_o    <= (state_next == ST_INT);   // see RQ5
            sw_ref_buf_o    <= (state_next == ST_DEINT); // see RQ7
            sw_clear_loop_o <= (state_next == ST_CLR);   // see RQ11
            if (state_reg == ST_INT && state_next == ST_DEINT) begin
                ref_pol_sel_o <= comp_s_reg;             // see RQ7
            end
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    assign status_word = {22'h00_0000,
                          req_s_reg,
                          or_last_reg,
                          result_high_flag_o,
                          result_low_flag_o,
                          polarity_o,
                          busy_o,
                          state_reg};

    // ****************************************
    // Wishbone slave
    // ****************************************
    // Answers one cycle after the request; unmapped offsets read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_reg <= `DSPS_CTRL_RST;
            sw_go_reg <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o  <= bus_req;
            sw_go_reg <= 1'b0;
            if (ctrl_wr) begin
                ctrl_reg[`DSPS_CTRL_RUN_BIT] <= wb_dat_i[`DSPS_CTRL_RUN_BIT];
                sw_go_reg <= wb_dat_i[`DSPS_CTRL_GO_BIT];
            end
            if (bus_req) begin
                case (wb_adr_i)
                    `DSPS_CTRL_OFS: begin
                        wb_dat_o <= {31'h0000_0000, ctrl_reg[`DSPS_CTRL_RUN_BIT]};
                    end
                    `DSPS_STAT_OFS: begin
                        wb_dat_o <= status_word;
                    end
                    `DSPS_RESULT_OFS: begin
                        wb_dat_o <= {16'h0000, result_o};
                    end
                    `DSPS_PCNT_OFS: begin
                        wb_dat_o <= {16'h0000, cnt_reg};
                    end
                    default: begin
                        wb_dat_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// [verif/dsps_seq_sva.sv]
// Concurrent checks on the sequencer ports
`default_nettype none
module dsps_seq_sva #(
    parameter [15:0] INT_CYC   = 16'h2710,
    parameter [15:0] DEINT_CYC = 16'h4E21
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        sw_in_common_o,
    input wire logic        sw_null_loop_o,
    input wire logic        sw_in_pins_o,
    input wire logic        sw_ref_buf_o,
    input wire logic        ref_pol_sel_o,
    input wire logic        sw_clear_loop_o,
    input wire logic        busy_o,
    input wire logic        result_low_flag_o,
    input wire logic        result_high_flag_o,
    input wire logic        polarity_o,
    input wire logic        latch_strobe_o,
    input wire logic [15:0] result_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] bw;
    logic [15:0] ic;
    logic [15:0] rc;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // Run lengths of busy, integration, return
    // ****************************************
    always_ff @(posedge clk_i) begin
        bw <= (rst_i || !busy_o) ? 16'h0000 : bw + 16'h0001;
        ic <= (rst_i || !sw_in_pins_o) ? 16'h0000 : ic + 16'h0001;
        rc <= (rst_i || !sw_ref_buf_o) ? 16'h0000 : rc + 16'h0001;
    end
    chk_null_switches: assert property (sw_in_common_o |-> sw_null_loop_o && !sw_in_pins_o)
        else $error("null switch set wrong");
    chk_int_length: assert property ($fell(sw_in_pins_o) |-> ic == INT_CYC)
        else $error("integration length wrong");
    chk_return_max: assert property (sw_ref_buf_o |-> rc < DEINT_CYC)
        else $error("return phase too long");
    chk_busy_rise: assert property ($rose(busy_o) |-> $rose(sw_in_pins_o))
        else $error("busy rise not at integration");
    chk_busy_fall: assert property ($fell(busy_o) |-> $fell(sw_ref_buf_o) && sw_clear_loop_o)
        else $error("busy fall not at return end");
    chk_busy_width: assert property ($fell(busy_o) |=> result_o == $past(bw) - INT_CYC - 16'h0001)
        else $error("busy width not int plus result plus one");
    chk_strobe_after: assert property ($fell(busy_o) |=> latch_strobe_o ##1 !latch_strobe_o)
        else $error("latch strobe misplaced");
    chk_flag_clear: assert property (sw_in_pins_o |-> !result_low_flag_o)
        else $error("low flag not cleared");
    chk_high_clear: assert property (sw_ref_buf_o |-> !result_high_flag_o)
        else $error("high flag not cleared");
    chk_ref_pol: assert property (sw_ref_buf_o |-> ref_pol_sel_o == polarity_o)
        else $error("reference terminal select wrong");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
endmodule
bind dsps_sequencer dsps_seq_sva #(.INT_CYC(INT_CYC), .DEINT_CYC(DEINT_CYC)) u_sva (.*);
`default_nettype wire

// [verif/dsps_comp_model.sv]
// Comparator model of the integrator during integration and return
`default_nettype none
module dsps_comp_model (
    input wire logic        clk_i,
    input wire logic        in_pins_i,
    input wire logic        ref_buf_i,
    input wire logic        pol_i,
    input wire logic [15:0] cross_i,
    output var logic        comp_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt = 16'h0000;
    initial comp_o = 1'b0;
    // Output follows the input sign until the ramp has run cross_i cycles
    always @(posedge clk_i) begin
        if (in_pins_i) begin
            cnt <= 16'h0000;
            comp_o <= pol_i;
        end else if (ref_buf_i) begin
            cnt <= cnt + 16'h0001;
            if (cnt + 16'h0001 >= cross_i)
                comp_o <= !pol_i;
        end
    end
endmodule
`default_nettype wire

// [verif/dsps_sequencer_tb_top.sv]
// Self-checking bench of the phase sequencer
`default_nettype none
module dsps_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [15:0] NI = 16'h0019, ND = 16'h0033, NC = 16'h0004, NCO = 16'h0010, NF = 16'h0064;
    logic clk_i = 0, rst_i = 1, req = 0, cyc = 0, stb = 0, we = 0, pol = 1, comp, ack, bq = 0;
    logic clr, pins, rbuf, rps, busy, lo, hi, pola, stro;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dout, sd = 32'h0001676E;
    logic [15:0] m = 16'h0005, res, held;
    logic icom, nl, rc;
    int fails = 0, tests_run = 0, cy = 0, t, gc = 0, gl = 0;
    int rq[$];
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cy <= cy + 1;
        bq <= busy;
        gc <= (busy === 1'b1) ? gc + 1 : 0;
        if (busy !== 1'b1 && bq === 1'b1) gl <= gc;
        if (busy === 1'b1 && bq !== 1'b1) rq.push_back(cy);
    end
    dsps_sequencer #(.NULL_CYC(16'h0014), .NULL_OR_CYC(16'h0008), .INT_CYC(NI), .DEINT_CYC(ND),
        .CLR_CYC(NC), .CLR_OR_CYC(NCO), .FRAME_CYC(NF)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .comp_i(comp),
        .run_req_i(req), .sw_in_common_o(icom), .sw_null_loop_o(nl), .sw_ref_charge_o(rc),
        .sw_in_pins_o(pins), .sw_ref_buf_o(rbuf), .ref_pol_sel_o(rps),
        .sw_clear_loop_o(clr), .busy_o(busy), .result_low_flag_o(lo),
        .result_high_flag_o(hi), .polarity_o(pola), .latch_strobe_o(stro), .result_o(res));
    dsps_comp_model u_comp (.clk_i(clk_i), .in_pins_i(pins), .ref_buf_i(rbuf), .pol_i(pol),
        .cross_i(m), .comp_o(comp));
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(negedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
        rdat = dout;
        cyc <= 0;
        stb <= 0;
        if (n >= 20) fails++;
    endtask
    task automatic conv(input logic p, input logic [15:0] mm, input logic orng);
        int w;
        @(posedge clk_i);
        pol <= p;
        m <= mm;
        w = 0;
        while (busy !== 1'b1 && w < 300) begin
            @(negedge clk_i);
            w++;
        end
        while (busy === 1'b1 && w < 900) begin
            @(negedge clk_i);
            w++;
        end
        w = 0;
        while (clr === 1'b1 && w < 100) begin
            @(negedge clk_i);
            w++;
        end
        chk("clear_len", orng ? NCO : NC, w);
        chk("polarity", p, pola);
        chk("ref_sel", p, rps);
        chk("high_flag", 0, hi);
        chk("gated", gl - NI - 1, res);
        chk("result", 1, orng ? res === ND - 16'h0001 : res >= mm && res <= mm + 3);
        if (!orng) chk("low_flag", 1, lo);
    endtask
    task automatic pulse;
        @(posedge clk_i);
        req <= 1;
        repeat (3) @(posedge clk_i);
        req <= 0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        repeat (3) @(negedge clk_i);
        chk("reset", 32'h0007_0000, {busy, pins, rbuf, clr, icom, nl, rc, res});
        wb(0, 4'h4, 0);
        chk("status", 32'h1, rdat);
        wb(0, 4'h2, 0);
        chk("unmapped", 32'h0, rdat);
        wb(1, 4'h0, 32'h2);
        conv(1, 16'h000C, 0);
        repeat (150) @(negedge clk_i);
        chk("one_shot", 1, rq.size());
        wb(0, 4'h4, 0);
        chk("status_hold", 32'h61, rdat);
        req <= 1;
        for (int i = 0; i < 4; i++) begin
            sd = lf(sd);
            conv(sd[0], i == 2 ? 16'hFFFF : 16'(sd[8:4]) + 16'h0001, i == 2);
        end
        req <= 0;
        for (int k = 1; k < 4; k++) chk("period", NF, rq[k+1] - rq[k]);
        held = res;
        repeat (200) @(negedge clk_i);
        chk("hold", 5, rq.size());
        chk("held", held, res);
        t = cy;
        fork
            conv(0, 16'h0028, 0);
            begin
                pulse();
                wait (rbuf === 1'b1);
                pulse();
            end
        join
        chk("start", 1, rq[5] - t >= 1 && rq[5] - t <= 23);
        repeat (200) @(negedge clk_i);
        chk("ignored", 6, rq.size());
        conclude();
    end
endmodule
`default_nettype wire
